// File: dfcm_monitor.sv
/*
  drive frequency and current monitor: level, arrival and current
  detectors, ramp-time selection, jump stepping, jog priority.
  assumes: samples and drive status come from logic on sys_clk_i;
  software uses the plain register port.
*/
// The placing of the registers and strobed register access were decided locally.
// Function
// R01: level flag sets above detect level
// R02: level flag clears below level minus hysteresis
// R03: hysteresis is percent of detect level
// R04: target arrival band, percent of max
// R05: jump enable steps across jump band
// R06: accel time 2 below accel switchover
// R07: decel time 2 below decel switchover
// R08: switching only motor 1, no terminal select
// R09: jog priority switches to terminal jog
// R10: second level detector like the first
// R11: two frequency window detectors
// R12: zero current flag after delay
// R13: over current flag after delay, zero disables
// R14: two current window detectors
// R15: both jump points zero disables jumping
// R16: timers restart and flags drop on lapse
// R17: all detectors use one shared sample
`timescale 1ns/1ps
`default_nettype none
module dfcm_monitor
  import dfcm_pkg::*;
#(
  parameter int TICK_CYC = `DFCM_TICK_NS / `DFCM_CLK_NS
) (
  // clock and reset
  input  wire logic                sys_clk_i,
  input  wire logic                rst_i,
  // register port
  input  wire logic [`DFCM_AW-1:0] addr_i,
  input  wire logic [`DFCM_DW-1:0] wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [`DFCM_DW-1:0] rdata_o,
  output logic                     irq_o,
  // control core samples
  input  wire logic                update_i,
  input  wire dfcm_sample_t        sample_i,
  // drive status
  input  wire logic                running_i,
  input  wire logic                accel_i,
  input  wire logic                decel_i,
  input  wire logic                motor1_sel_i,
  input  wire logic                term_ramp_sel_i,
  input  wire logic                jog_req_i,
  // output terminals
  output logic [1:0]               level_flag_output_terminal_o,
  output logic [2:0]               arrival_flag_output_terminal_o,
  output logic [3:0]               current_flag_output_terminal_o,
  // ramp, jump and jog steering
  output logic                     accel_time2_o,
  output logic                     decel_time2_o,
  output logic                     jump_step_o,
  output logic [15:0]              jump_freq_o,
  output logic                     jog_switch_o
);

  // the tick counter is 20 bits wide
  if (TICK_CYC < 2 || TICK_CYC > 1048576) begin : g_chk
    $error("TICK_CYC out of range");
  end

  localparam logic [19:0] TICK_LAST = 20'(TICK_CYC - 1);

  // percentage of a base value, 0.1 % steps
  function automatic dfcm_word_t pct_of(input dfcm_word_t base,
                                        input dfcm_word_t pct);
    logic [31:0] prod;
    prod = 32'(base) * 32'(pct);
    pct_of = 16'(prod / `DFCM_PCT_FULL);
  endfunction

  // v within c plus or minus w, no wrap
  function automatic logic in_win(input dfcm_word_t v,
                                  input dfcm_word_t c,
                                  input dfcm_word_t w);
    in_win = ({1'b0, v} + {1'b0, w} >= {1'b0, c}) &&
             ({1'b0, v} <= {1'b0, c} + {1'b0, w});
  endfunction

  // level detector with hysteresis below the level
  function automatic logic lvl_det(input dfcm_word_t f,
                                   input dfcm_word_t lvl,
                                   input dfcm_word_t hys,
                                   input logic       prev);
    dfcm_word_t hw;
    dfcm_word_t lo;
    hw = pct_of(lvl, hys); // R03
    lo = (lvl > hw) ? lvl - hw : 16'h0000;
    if (f > lvl) begin
      lvl_det = 1'b1; // R01
    end else if (f < lo) begin
      lvl_det = 1'b0; // R02
    end else begin
      lvl_det = prev;
    end
  endfunction

  // word index of a byte address
  function automatic logic [5:0] reg_idx(input logic [7:0] a);
    reg_idx = a[7:2];
  endfunction

  // state after reset, configuration at its defaults
  function automatic dfcm_state_t rst_state();
    dfcm_state_t s;
    s = '0;
    s.cfg[`DFCM_R_FMAX] = `DFCM_RV_FMAX;
    s.cfg[`DFCM_R_LVL1] = `DFCM_RV_LVL;
    s.cfg[`DFCM_R_HYS1] = `DFCM_RV_HYS;
    s.cfg[`DFCM_R_LVL2] = `DFCM_RV_LVL;
    s.cfg[`DFCM_R_HYS2] = `DFCM_RV_HYS;
    s.cfg[`DFCM_R_WIN1] = `DFCM_RV_LVL;
    s.cfg[`DFCM_R_WIN2] = `DFCM_RV_LVL;
    s.cfg[`DFCM_R_ZCL]  = `DFCM_RV_ZCL;
    s.cfg[`DFCM_R_ZCD]  = `DFCM_RV_ZCD;
    s.cfg[`DFCM_R_OCL]  = `DFCM_RV_OCL;
    s.cfg[`DFCM_R_CWL1] = `DFCM_RV_CWL;
    s.cfg[`DFCM_R_CWL2] = `DFCM_RV_CWL;
    return s;
  endfunction

  localparam dfcm_state_t ST_RST = rst_state();

  dfcm_state_t st;       // registered state
  dfcm_state_t next_st;  // next state
  dfcm_word_t  f;        // sampled running frequency
  dfcm_word_t  c;        // sampled output current
  logic        tick;     // 10 ms delay tick
  logic        zc_cond;  // current at or below zero level
  logic        oc_cond;  // current at or above threshold
  logic        ramp_auto;// frequency-based ramp choice
  logic        jump_on;  // jumping live this cycle
  dfcm_word_t  half;     // half of the jump band
  logic [5:0]  widx;     // decoded address

  // next state of the whole monitor
  always_comb begin
    next_st = st;
    f       = st.samp.run_freq;
    c       = st.samp.out_cur;
    widx    = reg_idx(addr_i);
    tick    = (st.tick_cnt == TICK_LAST);
    // one sample per control update
    if (update_i) begin
      next_st.samp = sample_i; // R17
    end
    next_st.tick_cnt = tick ? 20'h00000 : st.tick_cnt + 20'h00001;

    // frequency level detectors
    next_st.flags.level[0] = lvl_det(f, st.cfg[`DFCM_R_LVL1],
      st.cfg[`DFCM_R_HYS1], st.flags.level[0]); // R01 R02
    next_st.flags.level[1] = lvl_det(f, st.cfg[`DFCM_R_LVL2],
      st.cfg[`DFCM_R_HYS2], st.flags.level[1]); // R10

    // target arrival and frequency windows
    next_st.flags.arrival[0] = in_win(f, st.samp.tgt_freq,
      pct_of(st.cfg[`DFCM_R_FMAX], st.cfg[`DFCM_R_ARRW])); // R04
    next_st.flags.arrival[1] = in_win(f, st.cfg[`DFCM_R_WIN1],
      pct_of(st.cfg[`DFCM_R_FMAX], st.cfg[`DFCM_R_WID1])); // R11
    next_st.flags.arrival[2] = in_win(f, st.cfg[`DFCM_R_WIN2],
      pct_of(st.cfg[`DFCM_R_FMAX], st.cfg[`DFCM_R_WID2])); // R11

    // zero current: qualify over ticks
    zc_cond = (c <= st.cfg[`DFCM_R_ZCL]);
    if (!zc_cond) begin
      next_st.zc_cnt = 16'h0000; // R16
    end else if (tick && st.zc_cnt != 16'hffff) begin
      next_st.zc_cnt = st.zc_cnt + 16'h0001;
    end
    next_st.flags.current[0] = zc_cond &&
      (st.zc_cnt > st.cfg[`DFCM_R_ZCD]); // R12 R16

    // over current: zero threshold turns it off
    oc_cond = (st.cfg[`DFCM_R_OCL] != 16'h0000) &&
              (c >= st.cfg[`DFCM_R_OCL]); // R13
    if (!oc_cond) begin
      next_st.oc_cnt = 16'h0000; // R16
    end else if (tick && st.oc_cnt != 16'hffff) begin
      next_st.oc_cnt = st.oc_cnt + 16'h0001;
    end
    next_st.flags.current[1] = oc_cond &&
      (st.oc_cnt > st.cfg[`DFCM_R_OCD]); // R13 R16

    // current windows
    next_st.flags.current[2] = in_win(c, st.cfg[`DFCM_R_CWL1],
      st.cfg[`DFCM_R_CWW1]); // R14
    next_st.flags.current[3] = in_win(c, st.cfg[`DFCM_R_CWL2],
      st.cfg[`DFCM_R_CWW2]); // R14

    // ramp time choice by frequency
    ramp_auto = motor1_sel_i && !term_ramp_sel_i; // R08
    next_st.drv.accel2 = ramp_auto && accel_i &&
      (f < st.cfg[`DFCM_R_ACCSW]); // R06
    next_st.drv.decel2 = ramp_auto && decel_i &&
      (f < st.cfg[`DFCM_R_DECSW]); // R07

    // jump across the band while ramping
    jump_on = st.cfg[`DFCM_R_CTRL][`DFCM_B_JUMP] &&
              (accel_i || decel_i) &&
              !(st.cfg[`DFCM_R_JMP1] == 16'h0000 &&
                st.cfg[`DFCM_R_JMP2] == 16'h0000); // R05 R15
    half = st.cfg[`DFCM_R_JMPB] >> 1;
    next_st.drv.jump_step = 1'b0;
    next_st.drv.jump_freq = f;
    if (jump_on && in_win(f, st.cfg[`DFCM_R_JMP1], half)) begin
      next_st.drv.jump_step = 1'b1; // R05
      next_st.drv.jump_freq = accel_i ?
        st.cfg[`DFCM_R_JMP1] + half : st.cfg[`DFCM_R_JMP1] - half;
    end else if (jump_on &&
                 in_win(f, st.cfg[`DFCM_R_JMP2], half)) begin
      next_st.drv.jump_step = 1'b1; // R05
      next_st.drv.jump_freq = accel_i ?
        st.cfg[`DFCM_R_JMP2] + half : st.cfg[`DFCM_R_JMP2] - half;
    end

    // jog priority while running
    next_st.drv.jog_switch = st.cfg[`DFCM_R_CTRL][`DFCM_B_JOG] &&
                             running_i && jog_req_i; // R09

    // sticky events: clear on read, a new rise wins
    if (rd_i && widx == `DFCM_R_ISTS) begin
      next_st.irq_sts = 9'h000;
    end
    next_st.irq_sts = next_st.irq_sts |
                      (next_st.flags & ~st.flags);

    // register writes
    if (wr_i) begin
      if (widx < 6'(`DFCM_NCFG)) begin
        next_st.cfg[widx] = wdata_i;
      end else if (widx == `DFCM_R_IMSK) begin
        next_st.irq_msk = wdata_i[8:0];
      end
    end

    // register reads, data in the next cycle
    next_st.rdata = 16'h0000;
    if (rd_i) begin
      if (widx < 6'(`DFCM_NCFG)) begin
        next_st.rdata = st.cfg[widx];
      end else if (widx == `DFCM_R_FLAGS) begin
        next_st.rdata = {7'h00, st.flags};
      end else if (widx == `DFCM_R_ISTS) begin
        next_st.rdata = {7'h00, st.irq_sts};
      end else if (widx == `DFCM_R_IMSK) begin
        next_st.rdata = {7'h00, st.irq_msk};
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign rdata_o = st.rdata;
  assign irq_o   = |(st.irq_sts & st.irq_msk);
  assign level_flag_output_terminal_o   = st.flags.level;
  assign arrival_flag_output_terminal_o = st.flags.arrival;
  assign current_flag_output_terminal_o = st.flags.current;
  assign accel_time2_o = st.drv.accel2;
  assign decel_time2_o = st.drv.decel2;
  assign jump_step_o   = st.drv.jump_step;
  assign jump_freq_o   = st.drv.jump_freq;
  assign jog_switch_o  = st.drv.jog_switch;

endmodule
`default_nettype wire

// File: dfcm_map.svh
/*
  register map, reset values and timing figures of the drive
  frequency and current monitor.
  assumes: included by the package by bare name; the monitor gets its macros through the package.
*/
`ifndef DFCM_MAP_SVH
`define DFCM_MAP_SVH
// bus widths
`define DFCM_AW        8
`define DFCM_DW        16
// config word indices (byte address = index * 4)
`define DFCM_R_CTRL    6'h00
`define DFCM_R_FMAX    6'h01
`define DFCM_R_LVL1    6'h02
`define DFCM_R_HYS1    6'h03
`define DFCM_R_LVL2    6'h04
`define DFCM_R_HYS2    6'h05
`define DFCM_R_ARRW    6'h06
`define DFCM_R_WIN1    6'h07
`define DFCM_R_WID1    6'h08
`define DFCM_R_WIN2    6'h09
`define DFCM_R_WID2    6'h0a
`define DFCM_R_ACCSW   6'h0b
`define DFCM_R_DECSW   6'h0c
`define DFCM_R_JMP1    6'h0d
`define DFCM_R_JMP2    6'h0e
`define DFCM_R_JMPB    6'h0f
`define DFCM_R_ZCL     6'h10
`define DFCM_R_ZCD     6'h11
`define DFCM_R_OCL     6'h12
`define DFCM_R_OCD     6'h13
`define DFCM_R_CWL1    6'h14
`define DFCM_R_CWW1    6'h15
`define DFCM_R_CWL2    6'h16
`define DFCM_R_CWW2    6'h17
`define DFCM_NCFG      24
// status words
`define DFCM_R_FLAGS   6'h18
`define DFCM_R_ISTS    6'h19
`define DFCM_R_IMSK    6'h1a
// control word bits
`define DFCM_B_JUMP    0
`define DFCM_B_JOG     1
// reset values: hz in 0.01, percent in 0.1, delay in 10 ms
`define DFCM_RV_FMAX   16'h1388
`define DFCM_RV_LVL    16'h1388
`define DFCM_RV_HYS    16'h0032
`define DFCM_RV_ZCL    16'h0032
`define DFCM_RV_ZCD    16'h000a
`define DFCM_RV_OCL    16'h07d0
`define DFCM_RV_CWL    16'h03e8
// full scale of a percentage field (100.0 %)
`define DFCM_PCT_FULL  32'h0000_03e8
// delay tick: 10 ms at 100 MHz
`define DFCM_TICK_NS   10000000
`define DFCM_CLK_NS    10
`endif

// File: dfcm_pkg.sv
/*
  types of the drive frequency and current monitor.
  assumes: dfcm_map.svh is on the include path.
*/
`default_nettype none
package dfcm_pkg;
  `include "dfcm_map.svh"
  typedef logic [15:0] dfcm_word_t;
  // one control-update sample
  typedef struct packed {
    dfcm_word_t run_freq; // 0.01 hz
    dfcm_word_t tgt_freq; // 0.01 hz
    dfcm_word_t out_cur;  // 0.1 % of rated
  } dfcm_sample_t;
  // terminal flags
  typedef struct packed {
    logic [1:0] level;    // level detector 2,1
    logic [2:0] arrival;  // window 2, window 1, target
    logic [3:0] current;  // window 2, window 1, over, zero
  } dfcm_flags_t;
  // ramp, jump and jog steering
  typedef struct packed {
    logic       accel2;
    logic       decel2;
    logic       jump_step;
    dfcm_word_t jump_freq;
    logic       jog_switch;
  } dfcm_drive_t;
  // whole state of the monitor
  typedef struct packed {
    dfcm_word_t [`DFCM_NCFG-1:0] cfg;
    dfcm_sample_t                samp;
    dfcm_flags_t                 flags;
    dfcm_drive_t                 drv;
    logic [19:0]                 tick_cnt;
    dfcm_word_t                  zc_cnt;
    dfcm_word_t                  oc_cnt;
    logic [8:0]                  irq_sts;
    logic [8:0]                  irq_msk;
    dfcm_word_t                  rdata;
  } dfcm_state_t;
endpackage
`default_nettype wire

// File: dfcm_term_model.sv
/*
  control system model: latches the output terminals each cycle.
  assumes: terminals are registered on sys_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module dfcm_term_model
  import dfcm_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // terminals from the monitor
  input  wire logic [1:0] level_i,
  input  wire logic [2:0] arrival_i,
  input  wire logic [3:0] current_i,
  // flags as the controller sees them
  output var dfcm_flags_t seen_o
);
  // terminal board latch, one cycle behind
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      seen_o <= '0;
    end else begin
      seen_o <= {level_i, arrival_i, current_i};
    end
  end
endmodule
`default_nettype wire

// File: dfcm_monitor_assertions.sv
/*
  port assertions of the monitor, bound into dfcm_monitor.
  assumes: one clock sys_clk_i, synchronous reset rst_i.
*/
`timescale 1ns/1ps
`default_nettype none
module dfcm_monitor_chk
  import dfcm_pkg::*;
#(
  parameter int TICK_CYC = 4
) (
  // clock, reset and register writes
  input wire logic         sys_clk_i, rst_i, wr_i,
  input wire logic [7:0]   addr_i,
  input wire logic [15:0]  wdata_i,
  // samples and drive status
  input wire logic         update_i, running_i, accel_i, decel_i,
  input wire logic         motor1_sel_i, term_ramp_sel_i, jog_req_i,
  input wire dfcm_sample_t sample_i,
  // monitor outputs
  input wire logic [1:0]   level_flag_output_terminal_o,
  input wire logic [3:0]   current_flag_output_terminal_o,
  input wire logic         accel_time2_o, decel_time2_o,
  input wire logic         jump_step_o, jog_switch_o,
  input wire logic [15:0]  jump_freq_o
);
  logic [1:0]  ctrl;           // control word shadow
  logic [15:0] lvl1, zcl, ocl; // level shadows
  logic [15:0] fc, cc;         // captured frequency, current
  logic        jog_c;          // jog request qualified
  assign jog_c = ctrl[1] & running_i & jog_req_i;
  // shadow of config and sample
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl <= 2'h0;
      lvl1 <= 16'h1388;
      zcl <= 16'h0032;
      ocl <= 16'h07d0;
      fc <= 16'h0;
      cc <= 16'h0;
    end else begin
      if (update_i) begin
        fc <= sample_i.run_freq;
        cc <= sample_i.out_cur;
      end
      if (wr_i && addr_i[7:2] == 6'h00) ctrl <= wdata_i[1:0];
      if (wr_i && addr_i[7:2] == 6'h02) lvl1 <= wdata_i;
      if (wr_i && addr_i[7:2] == 6'h10) zcl <= wdata_i;
      if (wr_i && addr_i[7:2] == 6'h12) ocl <= wdata_i;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_jog_req; jog_c; endsequence
  sequence s_jog_seen; ##1 jog_switch_o; endsequence
  a_jog_on: assert property (s_jog_req |-> s_jog_seen)
    else $error("jog switch missing");
  a_jog_off: assert property (!jog_c |=> !jog_switch_o)
    else $error("jog switch without request");
  a_accel_gate: assert property ((!motor1_sel_i || term_ramp_sel_i
    || !accel_i) |=> !accel_time2_o) else $error("accel time 2 ungated");
  a_decel_gate: assert property ((!motor1_sel_i || term_ramp_sel_i
    || !decel_i) |=> !decel_time2_o) else $error("decel time 2 ungated");
  a_jump_gate: assert property ((!ctrl[0] || !(accel_i || decel_i))
    |=> !jump_step_o) else $error("jump step ungated");
  a_jump_pass: assert property (!jump_step_o
    |-> jump_freq_o == $past(fc)) else $error("jump freq not sample");
  a_level_rise: assert property ($rose(level_flag_output_terminal_o[0])
    |-> $past(fc) > $past(lvl1)) else $error("level flag set early");
  a_over_cur: assert property (current_flag_output_terminal_o[1]
    && $past(cc) == $past(cc, 2) && $past(ocl) == $past(ocl, 2)
    |-> $past(cc) >= $past(ocl) && $past(ocl) != 16'h0)
    else $error("over current flag wrong");
  a_zero_cur: assert property (current_flag_output_terminal_o[0]
    && $past(cc) == $past(cc, 2) && $past(zcl) == $past(zcl, 2)
    |-> $past(cc) <= $past(zcl)) else $error("zero current flag wrong");
endmodule
bind dfcm_monitor dfcm_monitor_chk #(.TICK_CYC(TICK_CYC)) u_chk (
  .sys_clk_i, .rst_i, .wr_i, .addr_i, .wdata_i, .update_i, .running_i,
  .accel_i, .decel_i, .motor1_sel_i, .term_ramp_sel_i, .jog_req_i,
  .sample_i, .level_flag_output_terminal_o, .current_flag_output_terminal_o,
  .accel_time2_o, .decel_time2_o, .jump_step_o, .jog_switch_o, .jump_freq_o);
`default_nettype wire

// File: dfcm_monitor_test.sv
/*
  self-checking bench of the frequency and current monitor.
  assumes: package, terminal model and bound checker compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module dfcm_monitor_test
  import dfcm_pkg::*;
();
  logic clk, rst, wr, rd, upd, probe, jprobe;
  logic rd_q = 1'b0;  // read issued last cycle
  logic [7:0] addr;
  logic [15:0] wdata, got, exp_v;
  logic [5:0] drv;    // running accel decel motor1 term jog
  logic [31:0] seed;
  dfcm_sample_t samp;
  logic [15:0] q[$];  // expected results in order
  int mismatches, n_checks;
  wire logic [15:0] rdata, jfreq;
  wire logic irq, acc2, dec2, jstep, jogsw;
  wire logic [1:0] lvl;
  wire logic [2:0] arr;
  wire logic [3:0] cur;
  wire dfcm_flags_t seen;
  localparam logic [5:0] t1_i [9] = '{6'h00, 6'h01, 6'h03, 6'h10, 6'h11,
    6'h12, 6'h14, 6'h1b, 6'h18};
  localparam logic [15:0] t1_v [9] = '{16'h0000, 16'h1388, 16'h0032,
    16'h0032, 16'h000a, 16'h07d0, 16'h03e8, 16'h0000, 16'h0010};
  localparam logic [15:0] t2_f [4] = '{16'h1389, 16'h1388, 16'h128e,
    16'h128d};
  localparam logic [8:0] t2_fl [4] = '{9'h19c, 9'h1fc, 9'h19c, 9'h01c};
  dfcm_monitor #(.TICK_CYC(4)) dut (
    .sys_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq),
    .update_i(upd), .sample_i(samp), .running_i(drv[5]),
    .accel_i(drv[4]), .decel_i(drv[3]), .motor1_sel_i(drv[2]),
    .term_ramp_sel_i(drv[1]), .jog_req_i(drv[0]),
    .level_flag_output_terminal_o(lvl), .arrival_flag_output_terminal_o(arr),
    .current_flag_output_terminal_o(cur), .accel_time2_o(acc2),
    .decel_time2_o(dec2), .jump_step_o(jstep), .jump_freq_o(jfreq),
    .jog_switch_o(jogsw));
  dfcm_term_model u_ctl (.sys_clk_i(clk), .rst_i(rst), .level_i(lvl),
    .arrival_i(arr), .current_i(cur), .seen_o(seen));
  // 100 mhz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // accel2 decel2 jump jog expected from drive status
  function automatic logic [3:0] steer(input logic [5:0] d, input logic en);
    return {d[2] & ~d[1] & d[4], d[2] & ~d[1] & d[3], en & (d[4] | d[3]),
      d[5] & d[0]};
  endfunction
  task automatic wr_reg(input logic [5:0] i, input logic [15:0] d);
    @(posedge clk);
    addr <= {i, 2'b00};
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [5:0] i, input logic [15:0] e);
    @(posedge clk);
    addr <= {i, 2'b00};
    rd <= 1'b1;
    q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic upd_s(input logic [15:0] f, input logic [15:0] c);
    @(posedge clk);
    samp <= '{f, f, c};
    upd <= 1'b1;
    @(posedge clk);
    upd <= 1'b0;
  endtask
  // settle, then have the watcher compare the port picture
  task automatic pr(input logic i, input logic [3:0] s, input logic [8:0] f);
    repeat (3) @(posedge clk);
    probe <= 1'b1;
    q.push_back({2'b00, i, s, f});
    @(posedge clk);
    probe <= 1'b0;
  endtask
  // have the watcher compare the jump target frequency
  task automatic pj(input logic [15:0] e);
    jprobe <= 1'b1;
    q.push_back(e);
    @(posedge clk);
    jprobe <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watcher: oldest note against read data, jump frequency or port picture
  always @(posedge clk) begin
    if (rd_q || probe || jprobe) begin
      got = rd_q ? rdata : jprobe ? jfreq :
        {2'b00, irq, acc2, dec2, jstep, jogsw, seen};
      exp_v = q.pop_front();
      n_checks++;
      if (got !== exp_v) begin
        mismatches++;
        $display("unexpected at %0t got %h exp %h", $time, got, exp_v);
      end
    end
    rd_q <= rd;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run();
  end
  initial begin
    {rst, wr, rd, upd, probe, jprobe} = 6'h20;
    {addr, wdata, samp, drv} = '0;
    seed = 32'hbef2;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wr_reg(6'h18, 16'hffff);
    for (int i = 0; i < 9; i++) rd_reg(t1_i[i], t1_v[i]);
    $display("test 1 done");
    wr_reg(6'h1a, 16'h0180);
    for (int i = 0; i < 4; i++) begin
      upd_s(t2_f[i], 16'h03e8);
      pr(i == 0, 4'h0, t2_fl[i]);
      if (i < 2) rd_reg(6'h19, i == 0 ? 16'h019c : 16'h0060);
    end
    $display("test 2 done");
    wr_reg(6'h11, 16'h0002);
    upd_s(16'h128d, 16'h001e);
    pr(1'b0, 4'h0, 9'h010);
    repeat (20) @(posedge clk);
    pr(1'b0, 4'h0, 9'h011);
    upd_s(16'h128d, 16'h003c);
    pr(1'b0, 4'h0, 9'h010);
    upd_s(16'h128d, 16'h001e);
    pr(1'b0, 4'h0, 9'h010);
    wr_reg(6'h13, 16'h0000);
    upd_s(16'h128d, 16'h07d0);
    repeat (6) @(posedge clk);
    pr(1'b0, 4'h0, 9'h012);
    wr_reg(6'h12, 16'h0000);
    pr(1'b0, 4'h0, 9'h010);
    $display("test 3 done");
    wr_reg(6'h0b, 16'h0bb8);
    wr_reg(6'h0c, 16'h0bb8);
    wr_reg(6'h0d, 16'h07d0);
    wr_reg(6'h0f, 16'h0064);
    wr_reg(6'h00, 16'h0003);
    upd_s(16'h07d0, 16'h07d0);
    for (int k = 0; k < 2; k++) begin
      if (k == 1) wr_reg(6'h0d, 16'h0000);
      for (int i = 0; i < 8; i++) begin
        seed = lfsr(seed);
        @(posedge clk);
        drv <= seed[5:0];
        pr(1'b0, steer(seed[5:0], k == 0), 9'h010);
        pj((k == 0 && seed[4]) ? 16'h0802 : (k == 0 && seed[3]) ?
          16'h079e : 16'h07d0);
      end
    end
    $display("test 4 done");
    complete_run();
  end
endmodule
`default_nettype wire
